// File: rtl/afh_top.sv
// Purpose: hands M, H and S codes to the logic controller with strobes
// Assumes: logic controller samples strobes at its scan, acks with done
// Notes: registers reached over a plain strobe port
`timescale 1ns/1ps
`default_nettype none
module afh_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic aux_done_ack,
   output logic m_code_strobe,
   output logic h_code_strobe,
   output logic s_code_strobe,
   output logic busy
);
   import afh_pkg::*;
   // ==========================================
   // reset release
   logic rst_meta, rst_sync;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end
   // ==========================================
   // configuration
   afh_word_t min_strobe_width, spindle_time_param;
   logic [7:0] spindle_order_param;
   logic [1:0] ch_sel;
   logic [31:0] query_val;
   wire logic wr_ctrl = wr && addr == A_CTRL;
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         min_strobe_width <= MIN_WIDTH_RST;
         spindle_time_param <= SPDL_TIME_RST;
         spindle_order_param <= SPDL_ORDER_RST;
         query_val <= 32'h0000_0000;
         ch_sel <= 2'b00;
      end else if (wr) begin
         if (addr == A_MIN_WIDTH) min_strobe_width <= wdata;
         if (addr == A_SPDL_TIME) spindle_time_param <= wdata;
         if (addr == A_SPDL_ORDER) spindle_order_param <= wdata[7:0];
         if (addr == A_QUERY) query_val <= wdata;
         if (addr == A_CTRL) ch_sel <= wdata[C_CH_LSB +: 2];
      end
   end
   // ==========================================
   // code banks, H and M, per channel
   logic [N_CH-1:0] h_wr, m_wr, bank_clr;
   logic [N_CH*7*32-1:0] h_all, m_all;
   logic [31:0] h_rd [N_CH];
   logic [31:0] m_rd [N_CH];
   wire logic code_wr = wr && addr[7:5] != 3'b000;
   wire logic [1:0] w_ch = addr[4:3];
   wire logic [2:0] w_slot = addr[2:0];
   always_comb begin
      for (int c = 0; c < N_CH; c++) begin
         h_wr[c] = code_wr && addr[7:5] == A_H_BASE[7:5] && w_ch == 2'(c);
         m_wr[c] = code_wr && addr[7:5] == A_M_BASE[7:5] && w_ch == 2'(c);
         bank_clr[c] = wr_ctrl && wdata[C_CLEAR] && ch_sel_w(wdata) == 2'(c);
      end
   end
   function automatic logic [1:0] ch_sel_w(input logic [31:0] d);
      ch_sel_w = d[C_CH_LSB +: 2];
   endfunction : ch_sel_w
   for (genvar c = 0; c < N_CH; c++) begin : g_ch
      afh_code_mem u_h (
         .clk(clk), .rst_n(rst_sync), .clear(bank_clr[c]), .wr_en(h_wr[c]),
         .wr_slot(w_slot), .wr_data(wdata), .rd_slot(w_slot), .rd_data(h_rd[c]),
         .all_data(h_all[c*224 +: 224])
      );
      afh_code_mem u_m (
         .clk(clk), .rst_n(rst_sync), .clear(bank_clr[c]), .wr_en(m_wr[c]),
         .wr_slot(w_slot), .wr_data(wdata), .rd_slot(w_slot), .rd_data(m_rd[c]),
         .all_data(m_all[c*224 +: 224])
      );
   end
   // ==========================================
   // compare-all, stops at first all-ones entry
   function automatic logic match_all(input logic [7*32-1:0] bank, input logic [31:0] v);
      logic hit, stop;
      hit = 1'b0;
      stop = 1'b0;
      for (int i = 0; i < N_CODE; i++) begin
         if (bank[i*32 +: 32] == CODE_NONE) stop = 1'b1;
         else if (!stop && bank[i*32 +: 32] == v) hit = 1'b1;
      end
      match_all = hit;
   endfunction : match_all
   logic [N_CH-1:0] h_code_match_per_channel, m_match;
   always_comb begin
      for (int c = 0; c < N_CH; c++) begin
         h_code_match_per_channel[c] = match_all(h_all[c*224 +: 224], query_val);
         m_match[c] = match_all(m_all[c*224 +: 224], query_val);
      end
   end
   wire logic h_code_match_all = h_code_match_per_channel[ch_sel];
   // ==========================================
   // spindle registers, by logic number
   afh_word_t spindle_value_reg [N_SPDL];
   wire logic s_wr = wr && addr[7:2] == A_S_BASE[7:2];
   function automatic logic [1:0] logic_num(input logic [7:0] ord, input logic [1:0] phys);
      logic [1:0] n;
      n = 2'(phys);
      for (int i = 0; i < N_SPDL; i++) begin
         if (ord[i*2 +: 2] == phys) n = 2'(i);
      end
      logic_num = n;
   endfunction : logic_num
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         for (int i = 0; i < N_SPDL; i++) spindle_value_reg[i] <= CODE_NONE;
      end else if (wr_ctrl && wdata[C_CLEAR]) begin
         for (int i = 0; i < N_SPDL; i++) spindle_value_reg[i] <= CODE_NONE;
      end else if (s_wr) begin
         // nonzero spindle time gates the programmed S value
         spindle_value_reg[logic_num(spindle_order_param, addr[1:0])] <=
            (spindle_time_param != 32'h0000_0000) ? wdata : CODE_NONE;
      end
   end
   // ==========================================
   // decoded M flags and per-spindle M record
   function automatic logic [3:0] dec_idx(input logic [31:0] m);
      unique case (m)
         32'h0000_0000: dec_idx = 4'h0;
         32'h0000_0001: dec_idx = 4'h1;
         32'h0000_0002: dec_idx = 4'h2;
         32'h0000_0003: dec_idx = 4'h3;
         32'h0000_0004: dec_idx = 4'h4;
         32'h0000_0005: dec_idx = 4'h5;
         32'h0000_0006: dec_idx = 4'h6;
         32'h0000_0008: dec_idx = 4'h7;
         32'h0000_0009: dec_idx = 4'h8;
         32'h0000_0013: dec_idx = 4'h9;
         32'h0000_001E: dec_idx = 4'hA;
         32'h0000_0029: dec_idx = 4'hB;
         32'h0000_002A: dec_idx = 4'hC;
         32'h0000_002B: dec_idx = 4'hD;
         32'h0000_002C: dec_idx = 4'hE;
         default: dec_idx = 4'hF;
      endcase
   endfunction : dec_idx
   logic [N_DEC-1:0] m_code_decoded_flag;
   logic [N_DEC-1:0] next_dec;
   logic [31:0] spindle_m_code [N_SPDL];
   logic go_m;
   always_comb begin
      next_dec = '0;
      for (int i = 0; i < N_CODE; i++) begin
         if (dec_idx(m_all[32'(ch_sel)*224 + i*32 +: 32]) != 4'hF) begin
            next_dec[dec_idx(m_all[32'(ch_sel)*224 + i*32 +: 32])] = 1'b1;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         m_code_decoded_flag <= '0;
         for (int i = 0; i < N_SPDL; i++) spindle_m_code[i] <= CODE_NONE;
      end else if (go_m) begin
         m_code_decoded_flag <= next_dec;
         // first M code of the block (slot 0) goes to the channel's spindle
         spindle_m_code[ch_sel] <= m_all[32'(ch_sel)*224 +: 32];
      end
   end
   logic [N_SPDL-1:0] spindle_m_code_match;
   always_comb begin
      for (int i = 0; i < N_SPDL; i++) begin
         spindle_m_code_match[i] = spindle_m_code[i] == query_val;
      end
   end
   // ==========================================
   // strobe sequencer
   afh_state_t state;
   afh_word_t cnt;
   logic m_sync, h_only, go_h, go_s;
   always_comb begin
      go_h = wr_ctrl && wdata[C_GO_H];
      go_m = wr_ctrl && wdata[C_GO_M];
      go_s = wr_ctrl && wdata[C_GO_S];
   end
   wire logic start = state == AFH_IDLE && (go_h || go_m || go_s);
   wire logic width_done = cnt <= 32'h0000_0001;
   // ack drop seen while the strobe width still runs
   logic ack_fell;
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         ack_fell <= 1'b0;
      end else if (start) begin
         ack_fell <= 1'b0;
      end else if (state == AFH_HOLD && !aux_done_ack) begin
         ack_fell <= 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         state <= AFH_IDLE;
         cnt <= 32'h0000_0000;
         m_code_strobe <= 1'b0;
         h_code_strobe <= 1'b0;
         s_code_strobe <= 1'b0;
         m_sync <= 1'b0;
         h_only <= 1'b0;
      end else begin
         unique case (state)
            AFH_IDLE: if (start) begin
               // all strobes of one block rise together
               m_code_strobe <= go_m;
               h_code_strobe <= go_h;
               s_code_strobe <= go_s;
               m_sync <= (go_m && wdata[C_M_SYNC]) || go_s;
               h_only <= go_h && !go_m && !go_s;
               cnt <= min_strobe_width;
               state <= AFH_HOLD;
            end
            AFH_HOLD: if (width_done) begin
               h_code_strobe <= 1'b0;
               if (m_sync) begin
                  state <= (aux_done_ack && !ack_fell) ? AFH_WAIT_LOW : AFH_WAIT_HIGH;
               end else begin
                  m_code_strobe <= 1'b0;
                  cnt <= min_strobe_width;
                  state <= h_only ? AFH_GAP : AFH_IDLE;
               end
            end else begin
               cnt <= cnt - 32'h0000_0001;
            end
            AFH_WAIT_LOW: if (!aux_done_ack) state <= AFH_WAIT_HIGH;
            AFH_WAIT_HIGH: if (aux_done_ack) begin
               cnt <= min_strobe_width;
               state <= AFH_ACK_HOLD;
            end
            AFH_ACK_HOLD: if (!aux_done_ack) begin
               state <= AFH_WAIT_HIGH;
            end else if (width_done) begin
               // one acknowledge ends every pending strobe
               m_code_strobe <= 1'b0;
               s_code_strobe <= 1'b0;
               state <= AFH_IDLE;
            end else begin
               cnt <= cnt - 32'h0000_0001;
            end
            AFH_GAP: if (width_done) state <= AFH_IDLE;
               else cnt <= cnt - 32'h0000_0001;
            default: state <= AFH_IDLE;
         endcase
      end
   end
   always_comb busy = state != AFH_IDLE;
   // ==========================================
   // read port
   logic [31:0] rdata_q;
   logic bank_sel, bank_m;
   logic [1:0] bank_ch;
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         rdata_q <= 32'h0000_0000;
         bank_sel <= 1'b0;
         bank_m <= 1'b0;
         bank_ch <= 2'b00;
      end else if (rd) begin
         bank_sel <= addr[7:5] == A_H_BASE[7:5] || addr[7:5] == A_M_BASE[7:5];
         bank_m <= addr[7:5] == A_M_BASE[7:5];
         bank_ch <= w_ch;
         rdata_q <= 32'h0000_0000;
         if (addr[7:2] == A_S_BASE[7:2]) rdata_q <= spindle_value_reg[addr[1:0]];
         else unique case (addr)
            A_CTRL: rdata_q <= {22'h00_0000, ch_sel, 8'h00};
            A_STATUS: rdata_q <= {26'h000_0000, busy, aux_done_ack, s_code_strobe,
               h_code_strobe, m_code_strobe, h_code_match_all};
            A_MIN_WIDTH: rdata_q <= min_strobe_width;
            A_SPDL_TIME: rdata_q <= spindle_time_param;
            A_SPDL_ORDER: rdata_q <= {24'h00_0000, spindle_order_param};
            A_QUERY: rdata_q <= query_val;
            A_MATCH: rdata_q <= {20'h0_0000, spindle_m_code_match, m_match,
               h_code_match_per_channel};
            A_DECODED: rdata_q <= {17'h0_0000, m_code_decoded_flag};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end
   // bank words come straight from the bank's own read register
   always_comb begin
      rdata = rdata_q;
      if (bank_sel) rdata = bank_m ? m_rd[bank_ch] : h_rd[bank_ch];
   end
endmodule : afh_top
`default_nettype wire

// File: shared/afh_pkg.sv
// Purpose: constants and types for the auxiliary function handoff block
// Assumes: 100 MHz clock, 32-bit code registers
// Notes: the behaviour list below is kept by rtl/afh_top.sv
//
// Behaviour
// - each H code of a block lands in its own 32-bit register, seven at most
// - unused code registers read all ones, always the highest-numbered ones
// - four channels, each with its own seven H registers and marks
// - compare-all H query gives 1 on a hit, 0 otherwise; all ones ends search
// - one compare-all H query per channel, testing only that channel
// - H codes go out at block start, no wait for any confirmation
// - S value goes to a 32-bit spindle register, all ones when not programmed
// - spindle register takes the S value only with nonzero spindle time
// - spindle start sends S and waits; orientation sends only the M code
// - four S registers indexed by spindle logic number; unused read all ones
// - spindle logic number follows the order in the spindle naming parameter
// - four per-spindle queries report whether an M code reached that spindle
// - M numbers load seven registers; listed M codes set a decoded flag
// - M strobe is raised for at least the minimum strobe width
// - synchronized M, or any M sent together with S, waits for done acknowledge before dropping; others do not
// - H strobe stands for the minimum width, then done with no acknowledge
// - consecutive H-only blocks are spaced by twice the minimum width
// - S transfer loads spindle registers, raises S strobe, waits for done
// - several M and S strobes together end on one single done acknowledge
// - minimum width should be at least the logic controller scan period
package afh_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned N_CH = 4;
   localparam int unsigned N_CODE = 7;
   localparam int unsigned N_SPDL = 4;
   localparam logic [31:0] CODE_NONE = 32'hFFFF_FFFF;
   localparam logic [31:0] MIN_WIDTH_RST = 32'h0000_03E8;
   localparam logic [7:0] SPDL_ORDER_RST = 8'hE4;
   localparam logic [31:0] SPDL_TIME_RST = 32'h0000_0001;
   localparam logic [3:0] CH_SEL_LSB = 4'h8;
   // register map, word offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h01;
   localparam logic [7:0] A_MIN_WIDTH = 8'h02;
   localparam logic [7:0] A_SPDL_TIME = 8'h03;
   localparam logic [7:0] A_SPDL_ORDER = 8'h04;
   localparam logic [7:0] A_QUERY = 8'h05;
   localparam logic [7:0] A_MATCH = 8'h06;
   localparam logic [7:0] A_DECODED = 8'h07;
   localparam logic [7:0] A_SPDL_M = 8'h08;
   localparam logic [7:0] A_S_BASE = 8'h10;
   localparam logic [7:0] A_H_BASE = 8'h20;
   localparam logic [7:0] A_M_BASE = 8'h40;
   // control bits
   localparam int unsigned C_GO_H = 0;
   localparam int unsigned C_GO_M = 1;
   localparam int unsigned C_M_SYNC = 2;
   localparam int unsigned C_GO_S = 3;
   localparam int unsigned C_CLEAR = 4;
   localparam int unsigned C_CH_LSB = 8;
   // decoded M codes: 00 01 02 03 04 05 06 08 09 19 30 41 42 43 44
   localparam int unsigned N_DEC = 15;
   typedef logic [31:0] afh_word_t;
   typedef enum logic [2:0] {
      AFH_IDLE, AFH_HOLD, AFH_WAIT_LOW, AFH_WAIT_HIGH, AFH_ACK_HOLD, AFH_GAP
   } afh_state_t;
endpackage : afh_pkg

// File: rtl/afh_code_mem.sv
// Purpose: one bank of seven 32-bit code registers for one channel
// Assumes: writes fill from slot 0 upward, clear sets all ones
// Notes: registered read port
`timescale 1ns/1ps
`default_nettype none
module afh_code_mem (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic wr_en,
   input wire logic [2:0] wr_slot,
   input wire logic [31:0] wr_data,
   input wire logic [2:0] rd_slot,
   output logic [31:0] rd_data,
   output logic [7*32-1:0] all_data
);
   import afh_pkg::*;
   afh_word_t mem [N_CODE];
   // ==========================================
   // storage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < N_CODE; i++) begin
            mem[i] <= CODE_NONE;
         end
      end else if (clear) begin
         for (int i = 0; i < N_CODE; i++) begin
            mem[i] <= CODE_NONE;
         end
      end else if (wr_en && wr_slot < 3'(N_CODE)) begin
         mem[wr_slot] <= wr_data;
      end
   end
   // ==========================================
   // read port
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= CODE_NONE;
      end else if (rd_slot < 3'(N_CODE)) begin
         rd_data <= mem[rd_slot];
      end else begin
         rd_data <= CODE_NONE;
      end
   end
   always_comb begin
      for (int i = 0; i < N_CODE; i++) begin
         all_data[i*32 +: 32] = mem[i];
      end
   end
endmodule : afh_code_mem
`default_nettype wire

// File: bench/afh_top_properties.sv
// Purpose: strobe timing checks on the handoff block
// Assumes: sees only the afh_top ports
// Notes: bound to afh_top below
`timescale 1ns/1ps
`default_nettype none
module afh_top_properties import afh_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic aux_done_ack,
   input wire logic m_code_strobe,
   input wire logic h_code_strobe,
   input wire logic s_code_strobe,
   input wire logic busy
);
   // ==========
   // helpers
   logic [31:0] mw, hc, mc, bc, ac;
   logic h_only, m_sync, go;
   assign go = wr && addr == A_CTRL && !busy;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mw <= MIN_WIDTH_RST;
      end else if (wr && addr == A_MIN_WIDTH) begin
         mw <= wdata;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hc <= '0;
         mc <= '0;
         bc <= '0;
         ac <= '0;
      end else begin
         hc <= h_code_strobe ? hc + 1 : '0;
         mc <= m_code_strobe ? mc + 1 : '0;
         bc <= busy ? bc + 1 : '0;
         ac <= aux_done_ack ? ac + 1 : '0;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         h_only <= 1'b0;
         m_sync <= 1'b0;
      end else if (go) begin
         h_only <= wdata[C_GO_H] && !wdata[C_GO_M] && !wdata[C_GO_S];
         m_sync <= wdata[C_M_SYNC] || wdata[C_GO_S];
      end
   end
   // ==========
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_h_start; go && wdata[C_GO_H] |=> h_code_strobe && busy; endproperty
   a_h_start: assert property (p_h_start) else $error("h start");
   property p_m_start; go && wdata[C_GO_M] |=> m_code_strobe; endproperty
   a_m_start: assert property (p_m_start) else $error("m start");
   property p_s_start; go && wdata[C_GO_S] |=> s_code_strobe; endproperty
   a_s_start: assert property (p_s_start) else $error("s start");
   property p_h_width; $fell(h_code_strobe) |-> hc == mw; endproperty
   a_h_width: assert property (p_h_width) else $error("h width");
   property p_m_min; $fell(m_code_strobe) |-> mc >= mw; endproperty
   a_m_min: assert property (p_m_min) else $error("m width");
   property p_m_nosync; $fell(m_code_strobe) && !m_sync |-> mc == mw; endproperty
   a_m_nosync: assert property (p_m_nosync) else $error("m unsync");
   property p_s_ack; $fell(s_code_strobe) |-> $past(aux_done_ack) && ac >= mw; endproperty
   a_s_ack: assert property (p_s_ack) else $error("s ack");
   property p_m_ack;
      $fell(m_code_strobe) && m_sync |-> $past(aux_done_ack) && ac >= mw;
   endproperty
   a_m_ack: assert property (p_m_ack) else $error("m ack");
   property p_both; m_code_strobe && s_code_strobe |=> m_code_strobe == s_code_strobe; endproperty
   a_both: assert property (p_both) else $error("m s apart");
   property p_h_gap; $fell(busy) && h_only |-> bc == {mw[30:0], 1'b0}; endproperty
   a_h_gap: assert property (p_h_gap) else $error("h gap");
   c_h: cover property ($fell(h_code_strobe));
   c_ms: cover property (m_code_strobe && s_code_strobe);
   c_mu: cover property ($fell(m_code_strobe) && !m_sync);
endmodule : afh_top_properties
bind afh_top afh_top_properties u_props (.clk(clk), .rst_n(rst_n), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .aux_done_ack(aux_done_ack),
   .m_code_strobe(m_code_strobe), .h_code_strobe(h_code_strobe),
   .s_code_strobe(s_code_strobe), .busy(busy));
`default_nettype wire

// File: bench/afh_plc_model.sv
// Purpose: logic controller answering strobes with done
// Assumes: strobes looked at once a scan
// Notes: exec_cycles at least 1
`timescale 1ns/1ps
`default_nettype none
module afh_plc_model #(parameter int SCAN = 2) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic m_code_strobe,
   input wire logic s_code_strobe,
   input wire logic [7:0] exec_cycles,
   output logic aux_done_ack
);
   logic [7:0] cnt, scan;
   logic seen;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_done_ack <= 1'b1;
         cnt <= '0;
         scan <= '0;
         seen <= 1'b0;
      end else begin
         scan <= (scan == 8'(SCAN - 1)) ? '0 : scan + 8'h01;
         if (cnt != '0) begin
            cnt <= cnt - 8'h01;
            aux_done_ack <= cnt == 8'h01;
         end else if (scan == '0 && (m_code_strobe || s_code_strobe) && !seen) begin
            aux_done_ack <= 1'b0;
            cnt <= exec_cycles;
            seen <= 1'b1;
         end else if (!m_code_strobe && !s_code_strobe) begin
            seen <= 1'b0;
         end
      end
   end
endmodule : afh_plc_model
`default_nettype wire

// File: bench/aux_function_handoff_bench.sv
// Purpose: self-checking bench for the handoff block
// Assumes: min width set to 4 cycles
// Notes: reads checked through a queue of notes
`timescale 1ns/1ps
`default_nettype none
module aux_function_handoff_bench;
   import afh_pkg::*;
   localparam logic [31:0] W = 32'h0000_0004;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = '0;
   logic [31:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_d = 1'b0;
   logic s_d = 1'b0;
   logic [7:0] exec_cycles = 8'h03;
   logic [31:0] hw = '0;
   logic [31:0] rdata, r;
   logic aux_done_ack, m_code_strobe, h_code_strobe, s_code_strobe, busy;
   logic [31:0] exp_q[$];
   logic [31:0] qv[4];
   logic [31:0] qe[4];
   int mismatches = 0;
   int total_checks = 0;
   always #5 clk = ~clk;
   afh_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .aux_done_ack(aux_done_ack), .m_code_strobe(m_code_strobe),
      .h_code_strobe(h_code_strobe), .s_code_strobe(s_code_strobe), .busy(busy));
   afh_plc_model #(.SCAN(2)) plc (.clk(clk), .rst_n(rst_n), .m_code_strobe(m_code_strobe),
      .s_code_strobe(s_code_strobe), .exec_cycles(exec_cycles), .aux_done_ack(aux_done_ack));
   // ==========
   // tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      if (mismatches == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask : rd_chk
   task automatic go(input logic [31:0] c);
      int n;
      wr_reg(A_CTRL, c);
      n = 0;
      @(posedge clk);
      while (busy !== 1'b0 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n == 2000) begin
         mismatches++;
         $display("[ERR] %0t busy never dropped", $time);
         report_and_stop();
      end
   endtask : go
   // ==========
   // watcher
   always @(posedge clk) begin
      rd_d <= rd;
      s_d <= s_code_strobe;
      if (rd_d) begin
         check(rdata, exp_q.pop_front());
      end
      if (h_code_strobe === 1'b1) begin
         hw <= hw + 32'h0000_0001;
      end else if (hw != '0) begin
         check(hw, W);
         hw <= '0;
      end
      if (s_d && s_code_strobe !== 1'b1) begin
         check({31'h0, m_code_strobe}, '0);
      end
   end
   initial begin : watchdog
      #200_000;
      mismatches++;
      $display("[ERR] %0t run hung", $time);
      report_and_stop();
   end
   // ==========
   // main sequence
   initial begin : main
      void'($urandom(32'h0000_2fde));
      r = 32'h1000_0000 | ($urandom() & 32'h0FFF_FFFF);
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      wr_reg(A_MIN_WIDTH, W);
      rd_chk(A_MIN_WIDTH, W);
      rd_chk(A_H_BASE | 8'h06, CODE_NONE);
      rd_chk(A_S_BASE | 8'h03, CODE_NONE);
      rd_chk(8'h80, '0);
      wr_reg(A_H_BASE, 32'h0000_000C);
      wr_reg(A_H_BASE | 8'h01, 32'h0000_0014);
      wr_reg(A_H_BASE | 8'h02, 32'h0000_0023);
      wr_reg(A_H_BASE | 8'h08, 32'h0000_0008);
      wr_reg(A_H_BASE | 8'h10, r);
      rd_chk(A_H_BASE | 8'h02, 32'h0000_0023);
      rd_chk(A_H_BASE | 8'h03, CODE_NONE);
      rd_chk(A_H_BASE | 8'h10, r);
      qv = '{32'h0000_0014, 32'h0000_0008, r, 32'h0000_004D};
      qe = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0000};
      for (int i = 0; i < 4; i++) begin
         wr_reg(A_QUERY, qv[i]);
         rd_chk(A_MATCH, qe[i]);
      end
      repeat (2) go(32'h0000_0001);
      wr_reg(A_M_BASE, 32'h0000_0003);
      wr_reg(A_M_BASE | 8'h01, 32'h0000_002C);
      go(32'h0000_0002);
      rd_chk(A_DECODED, 32'h0000_4008);
      wr_reg(A_QUERY, 32'h0000_0003);
      rd_chk(A_MATCH, 32'h0000_0110);
      wr_reg(A_SPDL_ORDER, 32'h0000_00E1);
      wr_reg(A_S_BASE, 32'h0000_0226);
      rd_chk(A_S_BASE | 8'h01, 32'h0000_0226);
      rd_chk(A_S_BASE, CODE_NONE);
      wr_reg(A_SPDL_TIME, '0);
      wr_reg(A_S_BASE | 8'h03, 32'h0000_03E8);
      rd_chk(A_S_BASE | 8'h03, CODE_NONE);
      wr_reg(A_SPDL_TIME, 32'h0000_0001);
      wr_reg(A_S_BASE | 8'h03, 32'h0000_03E8);
      rd_chk(A_S_BASE | 8'h03, 32'h0000_03E8);
      exec_cycles <= 8'h0C;
      go(32'h0000_000E);
      exec_cycles <= 8'h01;
      go(32'h0000_0006);
      go(32'h0000_0008);
      repeat (3) @(posedge clk);
      report_and_stop();
   end
endmodule : aux_function_handoff_bench
`default_nettype wire
